// [logic/fast_step_sequencer_regs.vh]
// Register map, field positions, reset values and timing constants of the step sequencer.
`ifndef FAST_STEP_SEQUENCER_REGS_VH
`define FAST_STEP_SEQUENCER_REGS_VH
// Register addresses (byte addresses, one word each).
`define FSS_ADDR_CTRL        8'h00
`define FSS_ADDR_CMD         8'h04
`define FSS_ADDR_TIMEBASE    8'h08
`define FSS_ADDR_LOOPS       8'h0C
`define FSS_ADDR_LAST_STEP   8'h10
`define FSS_ADDR_HOLD_VALUE  8'h14
`define FSS_ADDR_SEL_STEP    8'h18
`define FSS_ADDR_STEP_DATA   8'h1C
`define FSS_ADDR_FILL_START  8'h20
`define FSS_ADDR_FILL_END    8'h24
`define FSS_ADDR_FILL_SVAL   8'h28
`define FSS_ADDR_FILL_EVAL   8'h2C
`define FSS_ADDR_STATUS      8'h30
`define FSS_ADDR_PROGRESS    8'h34
`define FSS_ADDR_IRQ_STAT    8'h38
`define FSS_ADDR_IRQ_MASK    8'h3C
`define FSS_ADDR_STEP_COUNT  8'h40
// Control register bits.
`define FSS_CTRL_SEQ_EN      0
`define FSS_CTRL_LOAD_ON     1
`define FSS_CTRL_CR_MODE     2
`define FSS_CTRL_HOLD_EN     3
// Command register bits (write one to act).
`define FSS_CMD_INSERT       0
`define FSS_CMD_DELETE       1
`define FSS_CMD_FILL         2
// Step data word: trigger flag sits above the setpoint.
`define FSS_DATA_TRIG        16
// Interrupt bits.
`define FSS_IRQ_STEP         0
`define FSS_IRQ_LOOP         1
`define FSS_IRQ_DONE         2
`define FSS_IRQ_REFUSED      3
`define FSS_IRQ_W            4
// Limits and reset values.
`define FSS_MIN_STEPS        10'h003
`define FSS_FIRST_STEP       10'h001
`define FSS_LOOPS_INFINITE   14'h0000
`define FSS_RST_TIMEBASE     24'h000001
`define FSS_RST_LOOPS        14'h0001
`define FSS_MAX_LOOPS        14'h270F
// Time base unit is 25 us; one unit is 500 cycles of the 20 MHz clock.
`define FSS_TB_UNIT_NS       25000
`define FSS_CLK_NS           50
`define FSS_TB_UNIT_CYC      (`FSS_TB_UNIT_NS / `FSS_CLK_NS)
`define FSS_TB_MAX_UNITS     24'h005DC0
`endif

// [logic/fast_step_sequencer.v]
// Fast step sequencer: step table, linear fill, timed run engine and register port.
// ----------------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------------
// Summary of operation
// - Steps are numbered 1 to 1000; the selected step index is readable.
// - The table keeps at least three steps; deleting at three is refused.
// - Each step holds one setpoint, current or resistance per mode.
// - Fill writes evenly spaced setpoints from start value to end value.
// - Fill start and end steps accept 1 to 1000, plus start and end values.
// - Fill may run any number of times, before or after inserting steps.
// - Insert grows the step count by one and selects the new step.
// - Selection writes accept only existing steps up to the last step per loop.
// - Sequence mode needs an enable that is off after reset.
// - With sequence mode on, switching the load on starts the run at once.
// - While running, the current step and loop count are reported.
// - Completion is flagged after all programmed loops have finished.
// - Mode indicator shows when enabled and a distinct running state when on.
// - Every step lasts the same time base, 0.025 ms to 600 ms.
// - Loops run 1 to 9999 times, or forever when set to infinite.
// - After the final loop hold a setpoint if enabled, else release the load.
// - A last-step index from 1 to 1000 ends each loop.
//
// Chosen here: the address map and the address-and-strobe port.
`include "fast_step_sequencer_regs.vh"
`default_nettype none
module fast_step_sequencer #(
  parameter MAX_STEPS = 1000,
  parameter VAL_W = 16,
  parameter TB_UNIT_CYC = `FSS_TB_UNIT_CYC
) (
  // Clock, reset and enable.
  input wire clk,
  input wire rstn,
  input wire ce,
  // Register port.
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // Load drive and indicators.
  output reg [VAL_W-1:0] setpoint,
  output reg load_active,
  output reg constant_current_mode,
  output reg constant_resistance_mode,
  output reg step_trigger_output,
  output reg [1:0] sequence_mode_indicator,
  output reg irq
);
  localparam S_IDLE = 2'h0;
  localparam S_RUN = 2'h1;
  localparam S_FILL = 2'h2;
  localparam S_DONE = 2'h3;
  localparam MAXS = MAX_STEPS;

  // Table memory: setpoint plus trigger flag, indexed 1..MAX_STEPS.
  reg [VAL_W:0] table_mem [0:MAX_STEPS];

  reg [1:0] state_ff;
  reg [3:0] ctrl_ff;
  reg [23:0] timebase_ff;
  reg [13:0] loops_ff;
  reg [9:0] last_step_ff;
  reg [VAL_W-1:0] hold_val_ff;
  reg [9:0] sel_ff;
  reg [9:0] count_ff;
  reg [9:0] fill_s_ff;
  reg [9:0] fill_e_ff;
  reg [VAL_W-1:0] fill_sv_ff;
  reg [VAL_W-1:0] fill_ev_ff;
  reg [9:0] fill_i_ff;
  reg [VAL_W+10:0] fill_acc_ff;
  reg signed [VAL_W+10:0] fill_inc_ff;
  reg [9:0] run_step_ff;
  reg [13:0] run_loop_ff;
  reg [15:0] unit_cnt_ff;
  reg [23:0] tb_cnt_ff;
  reg [`FSS_IRQ_W-1:0] irq_stat_ff;
  reg [`FSS_IRQ_W-1:0] irq_mask_ff;
  reg load_on_q_ff;

  // Limit an index into 1..MAX_STEPS; used for the last-step, fill start and fill end indexes.
  function [9:0] clamp_idx;
    input [31:0] v;
    begin
      if (v[9:0] == 10'h000 || v > MAXS) begin
        clamp_idx = (v[9:0] == 10'h000) ? `FSS_FIRST_STEP : MAXS[9:0];
      end else begin
        clamp_idx = v[9:0];
      end
    end
  endfunction

  wire wr_cmd = ce && wr && addr == `FSS_ADDR_CMD && state_ff == S_IDLE;
  wire do_ins = wr_cmd && wdata[`FSS_CMD_INSERT] && count_ff < MAXS[9:0];
  wire do_del = wr_cmd && wdata[`FSS_CMD_DELETE] && count_ff > `FSS_MIN_STEPS;
  wire del_refused = wr_cmd && wdata[`FSS_CMD_DELETE] && !do_del;
  wire do_fill = wr_cmd && wdata[`FSS_CMD_FILL];
  wire load_on = ctrl_ff[`FSS_CTRL_LOAD_ON];
  wire seq_en = ctrl_ff[`FSS_CTRL_SEQ_EN];
  wire start_run = state_ff == S_IDLE && seq_en && load_on && !load_on_q_ff;
  wire tb_tick = unit_cnt_ff == TB_UNIT_CYC - 1 && tb_cnt_ff + 24'h000001 >= timebase_ff;
  wire loop_end = run_step_ff >= last_step_ff || run_step_ff >= count_ff;
  wire loops_over = loops_ff != `FSS_LOOPS_INFINITE && run_loop_ff >= loops_ff;
  wire [VAL_W:0] run_word = table_mem[run_step_ff];
  wire [VAL_W:0] first_word = table_mem[`FSS_FIRST_STEP];
  wire [VAL_W-1:0] fill_val = fill_acc_ff[VAL_W+9:10];

  // Event sets for the interrupt status.
  reg [`FSS_IRQ_W-1:0] ev;
  always @* begin
    ev = {`FSS_IRQ_W{1'b0}};
    ev[`FSS_IRQ_STEP] = state_ff == S_RUN && tb_tick;
    ev[`FSS_IRQ_LOOP] = state_ff == S_RUN && tb_tick && loop_end;
    ev[`FSS_IRQ_DONE] = state_ff == S_RUN && tb_tick && loop_end && loops_over;
    ev[`FSS_IRQ_REFUSED] = del_refused;
  end

  // Table writes: direct data, fill walker. Memory has no reset; fill writes setpoints only and keeps each trigger flag.
  always @(posedge clk) begin
    if (ce) begin
      if (state_ff == S_FILL) begin
        table_mem[fill_i_ff] <= {table_mem[fill_i_ff][VAL_W], fill_val};
      end else if (wr && addr == `FSS_ADDR_STEP_DATA && state_ff == S_IDLE) begin
        table_mem[sel_ff] <= wdata[VAL_W:0];
      end
    end
  end

  // Control, configuration, editing and run engine.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= S_IDLE;
      ctrl_ff <= 4'h0;
      timebase_ff <= `FSS_RST_TIMEBASE;
      loops_ff <= `FSS_RST_LOOPS;
      last_step_ff <= `FSS_MIN_STEPS;
      hold_val_ff <= {VAL_W{1'b0}};
      sel_ff <= `FSS_FIRST_STEP;
      count_ff <= `FSS_MIN_STEPS;
      fill_s_ff <= `FSS_FIRST_STEP;
      fill_e_ff <= `FSS_FIRST_STEP;
      fill_sv_ff <= {VAL_W{1'b0}};
      fill_ev_ff <= {VAL_W{1'b0}};
      fill_i_ff <= `FSS_FIRST_STEP;
      fill_acc_ff <= {(VAL_W+11){1'b0}};
      fill_inc_ff <= {(VAL_W+11){1'b0}};
      run_step_ff <= `FSS_FIRST_STEP;
      run_loop_ff <= 14'h0000;
      unit_cnt_ff <= 16'h0000;
      tb_cnt_ff <= 24'h000000;
      irq_stat_ff <= {`FSS_IRQ_W{1'b0}};
      irq_mask_ff <= {`FSS_IRQ_W{1'b0}};
      load_on_q_ff <= 1'b0;
    end else if (ce) begin
      load_on_q_ff <= load_on;
      // Set wins over the write-one-to-clear.
      if (wr && addr == `FSS_ADDR_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~wdata[`FSS_IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev;
      end
      if (wr) begin
        case (addr)
          `FSS_ADDR_CTRL: ctrl_ff <= wdata[3:0];
          `FSS_ADDR_TIMEBASE: begin
            if (wdata[23:0] == 24'h000000) begin
              timebase_ff <= `FSS_RST_TIMEBASE;
            end else if (wdata[23:0] > `FSS_TB_MAX_UNITS) begin
              timebase_ff <= `FSS_TB_MAX_UNITS;
            end else begin
              timebase_ff <= wdata[23:0];
            end
          end
          `FSS_ADDR_LOOPS: begin
            loops_ff <= (wdata[13:0] > `FSS_MAX_LOOPS) ? `FSS_MAX_LOOPS : wdata[13:0];
          end
          `FSS_ADDR_LAST_STEP: last_step_ff <= clamp_idx(wdata);
          `FSS_ADDR_HOLD_VALUE: hold_val_ff <= wdata[VAL_W-1:0];
          `FSS_ADDR_SEL_STEP: begin
            // Selection limited to existing steps and the last step per loop.
            if (wdata[9:0] != 10'h000 && wdata[9:0] <= count_ff
                && wdata[9:0] <= last_step_ff && wdata[31:10] == 22'h0) begin
              sel_ff <= wdata[9:0];
            end
          end
          `FSS_ADDR_FILL_START: fill_s_ff <= clamp_idx(wdata);
          `FSS_ADDR_FILL_END: fill_e_ff <= clamp_idx(wdata);
          `FSS_ADDR_FILL_SVAL: fill_sv_ff <= wdata[VAL_W-1:0];
          `FSS_ADDR_FILL_EVAL: fill_ev_ff <= wdata[VAL_W-1:0];
          `FSS_ADDR_IRQ_MASK: irq_mask_ff <= wdata[`FSS_IRQ_W-1:0];
          default: ;
        endcase
      end
      case (state_ff)
        S_IDLE: begin
          if (do_ins) begin
            count_ff <= count_ff + 10'h001;
            sel_ff <= count_ff + 10'h001;
          end else if (do_del) begin
            count_ff <= count_ff - 10'h001;
            if (sel_ff >= count_ff) begin
              sel_ff <= count_ff - 10'h001;
            end
          end else if (do_fill) begin
            // Fixed-point walker: value scaled by 1024, step increment precomputed.
            fill_i_ff <= fill_s_ff;
            fill_acc_ff <= {1'b0, fill_sv_ff, 10'h000};
            if (fill_e_ff > fill_s_ff) begin
              fill_inc_ff <= ($signed({1'b0, fill_ev_ff, 10'h000})
                - $signed({1'b0, fill_sv_ff, 10'h000}))
                / $signed({{(VAL_W+1){1'b0}}, fill_e_ff - fill_s_ff});
            end else begin
              fill_inc_ff <= {(VAL_W+11){1'b0}};
            end
            state_ff <= S_FILL;
          end else if (start_run) begin
            run_step_ff <= `FSS_FIRST_STEP;
            run_loop_ff <= 14'h0001;
            unit_cnt_ff <= 16'h0000;
            tb_cnt_ff <= 24'h000000;
            state_ff <= S_RUN;
          end
        end
        S_FILL: begin
          // The divide truncates, so the end step is loaded with the end value directly.
          if (fill_i_ff >= fill_e_ff) begin
            state_ff <= S_IDLE;
          end else if (fill_i_ff + 10'h001 == fill_e_ff) begin
            fill_i_ff <= fill_e_ff;
            fill_acc_ff <= {1'b0, fill_ev_ff, 10'h000};
          end else begin
            fill_i_ff <= fill_i_ff + 10'h001;
            fill_acc_ff <= fill_acc_ff + fill_inc_ff;
          end
        end
        S_RUN: begin
          if (!load_on || !seq_en) begin
            state_ff <= S_IDLE;
          end else begin
            if (unit_cnt_ff == TB_UNIT_CYC - 1) begin
              unit_cnt_ff <= 16'h0000;
              tb_cnt_ff <= tb_tick ? 24'h000000 : tb_cnt_ff + 24'h000001;
            end else begin
              unit_cnt_ff <= unit_cnt_ff + 16'h0001;
            end
            if (tb_tick) begin
              if (!loop_end) begin
                run_step_ff <= run_step_ff + 10'h001;
              end else if (loops_over) begin
                state_ff <= S_DONE;
              end else begin
                run_step_ff <= `FSS_FIRST_STEP;
                run_loop_ff <= run_loop_ff + 14'h0001;
              end
            end
          end
        end
        S_DONE: begin
          if (!load_on) begin
            state_ff <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Outputs from flip-flops: load drive, trigger pulse, indicators, read data.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
      setpoint <= {VAL_W{1'b0}};
      load_active <= 1'b0;
      constant_current_mode <= 1'b1;
      constant_resistance_mode <= 1'b0;
      step_trigger_output <= 1'b0;
      sequence_mode_indicator <= 2'h0;
      irq <= 1'b0;
    end else if (ce) begin
      constant_current_mode <= !ctrl_ff[`FSS_CTRL_CR_MODE];
      constant_resistance_mode <= ctrl_ff[`FSS_CTRL_CR_MODE];
      sequence_mode_indicator <= {seq_en && load_on, seq_en};
      irq <= |(irq_stat_ff & irq_mask_ff);
      // Trigger fires on the step's first cycle: run start or a tick moving on.
      step_trigger_output <= (start_run && first_word[VAL_W])
        || (state_ff == S_RUN && tb_tick && load_on && seq_en && !(loop_end && loops_over)
        && (loop_end ? first_word[VAL_W] : table_mem[run_step_ff + 10'h001][VAL_W]));
      if (state_ff == S_RUN) begin
        setpoint <= run_word[VAL_W-1:0];
        load_active <= 1'b1;
      end else if (state_ff == S_DONE) begin
        setpoint <= hold_val_ff;
        load_active <= ctrl_ff[`FSS_CTRL_HOLD_EN] && load_on;
      end else begin
        setpoint <= {VAL_W{1'b0}};
        load_active <= 1'b0;
      end
      if (rd) begin
        case (addr)
          `FSS_ADDR_CTRL: rdata <= {28'h0, ctrl_ff};
          `FSS_ADDR_TIMEBASE: rdata <= {8'h00, timebase_ff};
          `FSS_ADDR_LOOPS: rdata <= {18'h0, loops_ff};
          `FSS_ADDR_LAST_STEP: rdata <= {22'h0, last_step_ff};
          `FSS_ADDR_HOLD_VALUE: rdata <= {{(32-VAL_W){1'b0}}, hold_val_ff};
          `FSS_ADDR_SEL_STEP: rdata <= {22'h0, sel_ff};
          `FSS_ADDR_STEP_DATA: rdata <= {{(31-VAL_W){1'b0}}, table_mem[sel_ff]};
          `FSS_ADDR_FILL_START: rdata <= {22'h0, fill_s_ff};
          `FSS_ADDR_FILL_END: rdata <= {22'h0, fill_e_ff};
          `FSS_ADDR_FILL_SVAL: rdata <= {{(32-VAL_W){1'b0}}, fill_sv_ff};
          `FSS_ADDR_FILL_EVAL: rdata <= {{(32-VAL_W){1'b0}}, fill_ev_ff};
          `FSS_ADDR_STATUS: rdata <= {30'h0, state_ff};
          `FSS_ADDR_PROGRESS: rdata <= {2'h0, run_loop_ff, 6'h00, run_step_ff};
          `FSS_ADDR_IRQ_STAT: rdata <= {{(32-`FSS_IRQ_W){1'b0}}, irq_stat_ff};
          `FSS_ADDR_IRQ_MASK: rdata <= {{(32-`FSS_IRQ_W){1'b0}}, irq_mask_ff};
          `FSS_ADDR_STEP_COUNT: rdata <= {22'h0, count_ff};
          default: rdata <= 32'h00000000;
        endcase
      end else begin
        rdata <= 32'h00000000;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/fast_step_sequencer_sva.sv]
// Checker for the step sequencer port behaviour.
`include "fast_step_sequencer_regs.vh"
`default_nettype none
module fss_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Load and indicators.
  input wire logic load_active,
  input wire logic constant_current_mode,
  input wire logic constant_resistance_mode,
  input wire logic step_trigger_output,
  input wire logic [1:0] sequence_mode_indicator
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Write to the control word, decoded once for several properties.
  logic ctrl_wr;
  assign ctrl_wr = wr && (addr == `FSS_ADDR_CTRL);
  AST_RDATA_ZERO: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_RUN_IND: assert property (sequence_mode_indicator[1] |-> sequence_mode_indicator[0])
    else $error("running indicator without enable");
  AST_ONE_MODE: assert property (constant_current_mode != constant_resistance_mode)
    else $error("current and resistance mode not exclusive");
  AST_TRIG_PULSE: assert property (step_trigger_output |=> !step_trigger_output)
    else $error("trigger pulse longer than one cycle");
  AST_TRIG_LOAD: assert property (step_trigger_output |=> load_active)
    else $error("trigger without the load drawing");
  AST_START: assert property (ctrl_wr && wdata[1:0] == 2'h3 && sequence_mode_indicator == 2'h0
    |-> ##3 load_active)
    else $error("run did not start on load on");
  AST_EN_OFF: assert property (ctrl_wr && !wdata[0] |-> ##[1:3] sequence_mode_indicator == 2'h0)
    else $error("indicator stays on after disable");
  AST_CR_SEL: assert property (ctrl_wr && wdata[2] |-> ##[1:3] constant_resistance_mode)
    else $error("resistance mode not taken");
  AST_RELEASE: assert property (ctrl_wr && wdata[3:1] == 3'h0 |-> ##[1:3] !load_active)
    else $error("load not released");
endmodule
bind fast_step_sequencer fss_checker u_chk (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .load_active(load_active), .constant_current_mode(constant_current_mode),
  .constant_resistance_mode(constant_resistance_mode),
  .step_trigger_output(step_trigger_output),
  .sequence_mode_indicator(sequence_mode_indicator)
);
`default_nettype wire

// [tb/trig_instrument.sv]
// Model of the external instrument listening on the trigger output.
`default_nettype none
module trig_instrument (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Trigger and load level.
  input wire logic step_trigger_output,
  input wire logic [15:0] setpoint,
  // Observations.
  output int pulses,
  output int gap,
  output logic [15:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc;
  int last;
  logic seen;
  // Count pulses, spacing, and the level set one cycle after each pulse.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulses <= 0;
      cyc <= 0;
      last <= 0;
      gap <= 0;
      seen <= 1'b0;
      level <= 16'h0000;
    end else begin
      cyc <= cyc + 1;
      seen <= step_trigger_output;
      if (seen) level <= setpoint;
      if (step_trigger_output) begin
        pulses <= pulses + 1;
        gap <= cyc - last;
        last <= cyc;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/fast_step_sequencer_test.sv]
// Self-checking testbench of the step sequencer.
`include "fast_step_sequencer_regs.vh"
`default_nettype none
module fast_step_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] setpoint, level;
  logic load_active, cc, cr, trig, irq;
  logic [1:0] ind;
  int failures = 0, cmp_count = 0, pulses, gap;
  always #25 clk = ~clk;
  // Short time base unit keeps each step at four cycles.
  fast_step_sequencer #(.TB_UNIT_CYC(4)) u_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .setpoint(setpoint), .load_active(load_active),
    .constant_current_mode(cc), .constant_resistance_mode(cr),
    .step_trigger_output(trig), .sequence_mode_indicator(ind), .irq(irq)
  );
  trig_instrument u_inst (.clk(clk), .rstn(rstn), .step_trigger_output(trig),
    .setpoint(setpoint), .pulses(pulses), .gap(gap), .level(level));
  // ----------------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task give_verdict;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #(50 * 5000);
    failures++;
    give_verdict;
  end
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(`FSS_ADDR_STEP_COUNT, 32'h3);
    rd_chk(`FSS_ADDR_SEL_STEP, 32'h1);
    rd_chk(`FSS_ADDR_CTRL, 32'h0);
    rd_chk(8'hFC, 32'h0);
    chk({30'h0, ind}, 32'h0);
    chk({31'h0, cc}, 32'h1);
    $display("Test reset done");
    wr_reg(`FSS_ADDR_CMD, 32'h2);
    rd_chk(`FSS_ADDR_STEP_COUNT, 32'h3);
    rd_chk(`FSS_ADDR_IRQ_STAT, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wr_reg(`FSS_ADDR_IRQ_MASK, 32'hF);
    rd_chk(`FSS_ADDR_IRQ_MASK, 32'hF);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`FSS_ADDR_IRQ_STAT, 32'h8);
    rd_chk(`FSS_ADDR_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("Test delete refusal done");
    wr_reg(`FSS_ADDR_LAST_STEP, 32'h4);
    wr_reg(`FSS_ADDR_SEL_STEP, 32'h3);
    wr_reg(`FSS_ADDR_CMD, 32'h1);
    rd_chk(`FSS_ADDR_STEP_COUNT, 32'h4);
    rd_chk(`FSS_ADDR_SEL_STEP, 32'h4);
    wr_reg(`FSS_ADDR_SEL_STEP, 32'h5);
    rd_chk(`FSS_ADDR_SEL_STEP, 32'h4);
    $display("Test insert done");
    // The table has no reset, so clear every step's word and flag first.
    for (int s = 1; s <= 4; s++) begin
      wr_reg(`FSS_ADDR_SEL_STEP, s);
      wr_reg(`FSS_ADDR_STEP_DATA, 32'h0);
    end
    // Fill twice: the second pass must overwrite the first.
    for (int p = 0; p < 2; p++) begin
      wr_reg(`FSS_ADDR_FILL_START, 32'h1);
      wr_reg(`FSS_ADDR_FILL_END, 32'h4);
      wr_reg(`FSS_ADDR_FILL_SVAL, p ? 32'h10 : 32'h99);
      wr_reg(`FSS_ADDR_FILL_EVAL, 32'h40);
      wr_reg(`FSS_ADDR_CMD, 32'h4);
      repeat (8) @(posedge clk);
    end
    for (int s = 1; s <= 4; s++) begin
      wr_reg(`FSS_ADDR_SEL_STEP, s);
      rd_chk(`FSS_ADDR_STEP_DATA, 32'h10 * s);
    end
    wr_reg(`FSS_ADDR_SEL_STEP, 32'h2);
    wr_reg(`FSS_ADDR_STEP_DATA, 32'h10020);
    rd_chk(`FSS_ADDR_STEP_DATA, 32'h10020);
    wr_reg(`FSS_ADDR_IRQ_MASK, 32'h4);
    $display("Test fill done");
    wr_reg(`FSS_ADDR_LOOPS, 32'h2);
    wr_reg(`FSS_ADDR_CTRL, 32'h3);
    rd_chk(`FSS_ADDR_STATUS, 32'h1);
    chk({30'h0, ind}, 32'h3);
    chk({31'h0, load_active}, 32'h1);
    repeat (60) @(posedge clk);
    @(negedge clk);
    chk(pulses, 2);
    chk(gap, 16);
    chk({16'h0, level}, 32'h20);
    rd_chk(`FSS_ADDR_STATUS, 32'h3);
    rd_chk(`FSS_ADDR_IRQ_STAT, 32'h7);
    rd_chk(`FSS_ADDR_PROGRESS, 32'h00020004);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`FSS_ADDR_CTRL, 32'h5);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, load_active}, 32'h0);
    chk({30'h0, ind}, 32'h1);
    chk({31'h0, cr}, 32'h1);
    $display("Test run done");
    // Clock enable low: a write must leave the register untouched.
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(`FSS_ADDR_HOLD_VALUE, 32'h77);
    ce <= 1'b1;
    rd_chk(`FSS_ADDR_HOLD_VALUE, 32'h0);
    // One loop with hold at the end: the load keeps drawing the hold value.
    wr_reg(`FSS_ADDR_LOOPS, 32'h1);
    wr_reg(`FSS_ADDR_HOLD_VALUE, 32'h55);
    wr_reg(`FSS_ADDR_CTRL, 32'hB);
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk({31'h0, load_active}, 32'h1);
    chk({16'h0, setpoint}, 32'h55);
    chk(pulses, 3);
    rd_chk(`FSS_ADDR_PROGRESS, 32'h00010004);
    wr_reg(`FSS_ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({31'h0, load_active}, 32'h0);
    chk({30'h0, ind}, 32'h0);
    $display("Test hold done");
    give_verdict;
  end
endmodule
`default_nettype wire
